// ===== verilog/skip_pkg.sv
package skip_pkg;

   // ****************************************************************
   // widths and encodings
   // ****************************************************************
   localparam int DATA_W = 8;
   localparam int ADDR_W = 8;
   localparam int BIT_W = 3;
   localparam logic [DATA_W-1:0] INC_STEP = 8'h01;
   localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
   localparam logic [DATA_W-1:0] WORK_RESET = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_RESET = 8'h00;
   localparam logic [BIT_W-1:0] BIT_RESET = 3'h0;
   // cycles an instruction spends executing, plus one when skipping
   localparam int EXEC_CYCLES = 1;
   localparam int SKIP_CYCLES = 2;

   // conditional-skip operations handled by this unit
   typedef enum logic [1:0] {
      increment_skip_if_zero = 2'b00,
      increment_to_working_skip_if_zero = 2'b01,
      skip_if_bit_nonzero = 2'b10,
      skip_if_nonzero = 2'b11
   } skip_op_t;

   // sequencer states
   typedef enum logic [1:0] {
      st_idle = 2'b00,
      st_read = 2'b01,
      st_exec = 2'b10,
      st_dummy = 2'b11
   } skip_state_t;

endpackage : skip_pkg

// ===== verilog/skip_eval_if.sv
`timescale 1ns/10ps
`default_nettype none

// carries one operation to the evaluator and its verdict back
interface skip_eval_if;
   skip_pkg::skip_op_t op;
   logic [skip_pkg::DATA_W-1:0] data;
   logic [skip_pkg::BIT_W-1:0] bit_sel;
   logic [skip_pkg::DATA_W-1:0] result;
   logic write_back;
   logic to_working;
   logic skip;

   modport seq (output op, output data, output bit_sel,
                input result, input write_back, input to_working, input skip);
   modport eval (input op, input data, input bit_sel,
                 output result, output write_back, output to_working, output skip);
endinterface : skip_eval_if

`default_nettype wire

// ===== verilog/skip_eval.sv
`timescale 1ns/10ps
`default_nettype none

// ****************************************************************
// result and skip decision for one operand byte
// ****************************************************************
module skip_eval (
   skip_eval_if.eval ev // operation in, verdict out
);

   logic [skip_pkg::DATA_W-1:0] inc_val;

   // increment wraps silently; no carry leaves this module
   assign inc_val = ev.data + skip_pkg::INC_STEP; // RQ1

   // decode of the four operations
   always_comb
   begin
      ev.result = ev.data;
      ev.write_back = 1'b0;
      ev.to_working = 1'b0;
      ev.skip = 1'b0;
      case (ev.op)
         skip_pkg::increment_skip_if_zero:
         begin
            ev.result = inc_val; // RQ1
            ev.write_back = 1'b1; // RQ1
            ev.skip = (inc_val == skip_pkg::ZERO_BYTE); // RQ1
         end
         skip_pkg::increment_to_working_skip_if_zero:
         begin
            ev.result = inc_val; // RQ3
            ev.to_working = 1'b1; // RQ3
            ev.skip = (inc_val == skip_pkg::ZERO_BYTE); // RQ3
         end
         skip_pkg::skip_if_bit_nonzero:
         begin
            ev.skip = ev.data[ev.bit_sel]; // RQ5
         end
         skip_pkg::skip_if_nonzero:
         begin
            ev.write_back = 1'b1; // RQ6
            ev.skip = (ev.data != skip_pkg::ZERO_BYTE); // RQ6
         end
         default:
         begin
            ev.skip = 1'b0;
         end
      endcase
   end

endmodule : skip_eval

`default_nettype wire

// ===== verilog/skip_unit.sv
`timescale 1ns/10ps
`default_nettype none

// What this block does
// RQ1 - increment-and-skip adds one to the memory byte, writes it back and skips when it wraps to zero.
// RQ2 - a taken skip spends one dummy slot so the instruction lasts two instruction cycles.
// RQ3 - the working-register variant puts the incremented value in the working register only.
// RQ4 - a nonzero increment result continues in sequence with no extra cycle.
// RQ5 - the bit test skips when the selected bit of the byte is one.
// RQ6 - the byte test reads the byte, writes the same value back and skips when it is nonzero.
// RQ7 - none of these instructions touches any status flag.
module skip_unit (
   input wire logic clk_i, // 40 MHz core clock
   input wire logic rst_i, // async reset, active high
   input wire logic op_valid_i, // instruction issued this cycle
   input wire skip_pkg::skip_op_t op_code_i, // which skip operation
   input wire logic [skip_pkg::ADDR_W-1:0] op_addr_i, // data memory address
   input wire logic [skip_pkg::BIT_W-1:0] op_bit_i, // bit number for bit test
   input wire logic [skip_pkg::DATA_W-1:0] mem_rdata_i, // read data, one cycle after read
   output logic ready_o, // unit can take an instruction
   output logic mem_rd_o, // data memory read strobe
   output logic mem_we_o, // data memory write strobe
   output logic [skip_pkg::ADDR_W-1:0] mem_addr_o, // data memory address
   output logic [skip_pkg::DATA_W-1:0] mem_wdata_o, // data memory write data
   output logic [skip_pkg::DATA_W-1:0] working_register_o, // working register
   output logic working_we_o, // working register updated
   output logic flag_we_o, // status flag write, never raised
   output logic done_o, // instruction finished
   output logic skip_o, // discard the next fetched instruction
   output logic dummy_o // dummy slot in progress
);

   // ****************************************************************
   // sequencer
   // ****************************************************************
   skip_pkg::skip_state_t state;
   skip_pkg::skip_op_t op_q;
   logic [skip_pkg::BIT_W-1:0] bit_q;

   skip_eval_if ev ();

   assign ev.op = op_q;
   assign ev.data = mem_rdata_i;
   assign ev.bit_sel = bit_q;

   skip_eval u_eval (
      .ev(ev)
   );

   // state walk: read, execute, optional dummy slot
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         state <= skip_pkg::st_idle;
      end
      else
      begin
         case (state)
            skip_pkg::st_idle:
            begin
               if (op_valid_i)
               begin
                  state <= skip_pkg::st_read;
               end
            end
            skip_pkg::st_read:
            begin
               state <= skip_pkg::st_exec;
            end
            skip_pkg::st_exec:
            begin
               // no extra slot when nothing is skipped
               state <= ev.skip ? skip_pkg::st_dummy : skip_pkg::st_idle; // RQ2 RQ4
            end
            skip_pkg::st_dummy:
            begin
               state <= skip_pkg::st_idle; // RQ2
            end
            default:
            begin
               state <= skip_pkg::st_idle;
            end
         endcase
      end
   end

   // capture of the issued operation
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         op_q <= skip_pkg::increment_skip_if_zero;
         bit_q <= skip_pkg::BIT_RESET;
         mem_addr_o <= skip_pkg::ADDR_RESET;
      end
      else if (state == skip_pkg::st_idle && op_valid_i)
      begin
         op_q <= op_code_i;
         bit_q <= op_bit_i;
         mem_addr_o <= op_addr_i;
      end
   end

   // handshake and strobes, all registered
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         ready_o <= 1'b1;
         mem_rd_o <= 1'b0;
         done_o <= 1'b0;
         skip_o <= 1'b0;
         dummy_o <= 1'b0;
      end
      else
      begin
         ready_o <= (state == skip_pkg::st_exec && !ev.skip) ||
                    (state == skip_pkg::st_dummy) ||
                    (state == skip_pkg::st_idle && !op_valid_i);
         mem_rd_o <= (state == skip_pkg::st_idle && op_valid_i);
         done_o <= (state == skip_pkg::st_exec);
         skip_o <= (state == skip_pkg::st_exec) && ev.skip; // RQ2
         // the dummy slot hides the fetch of the instruction after the skipped one
         dummy_o <= (state == skip_pkg::st_exec) && ev.skip; // RQ2
      end
   end

   // ****************************************************************
   // results to memory and working register
   // ****************************************************************
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         mem_we_o <= 1'b0;
         mem_wdata_o <= skip_pkg::ZERO_BYTE;
      end
      else
      begin
         // byte test rewrites the same value; working variant leaves memory alone
         mem_we_o <= (state == skip_pkg::st_exec) && ev.write_back; // RQ1 RQ3 RQ6
         if (state == skip_pkg::st_exec)
         begin
            mem_wdata_o <= ev.result; // RQ1 RQ6
         end
      end
   end

   // working register only written by the working variant
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         working_register_o <= skip_pkg::WORK_RESET;
         working_we_o <= 1'b0;
      end
      else
      begin
         working_we_o <= (state == skip_pkg::st_exec) && ev.to_working; // RQ3
         if (state == skip_pkg::st_exec && ev.to_working)
         begin
            working_register_o <= ev.result; // RQ3
         end
      end
   end

   // flags are never written, whatever the result
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         flag_we_o <= 1'b0;
      end
      else
      begin
         flag_we_o <= 1'b0; // RQ7
      end
   end

   // ****************************************************************
   // assertions
   // ****************************************************************
   logic [skip_pkg::DATA_W-1:0] rd_q;
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         rd_q <= skip_pkg::ZERO_BYTE;
      end
      else
      begin
         rd_q <= mem_rdata_i;
      end
   end

   property p_inc_wb;
      @(posedge clk_i) disable iff (rst_i)
      (state == skip_pkg::st_exec && op_q == skip_pkg::increment_skip_if_zero) |=>
         mem_we_o && mem_wdata_o == rd_q + skip_pkg::INC_STEP &&
         skip_o == (rd_q == 8'hFF);
   endproperty
   a_inc_wb: assert property (p_inc_wb) else $error("increment write-back wrong"); // RQ1

   property p_skip_len;
      @(posedge clk_i) disable iff (rst_i)
      skip_o |-> dummy_o ##1 (!dummy_o && ready_o);
   endproperty
   a_skip_len: assert property (p_skip_len) else $error("skip slot length wrong"); // RQ2

   property p_work;
      @(posedge clk_i) disable iff (rst_i)
      (state == skip_pkg::st_exec && op_q == skip_pkg::increment_to_working_skip_if_zero) |=>
         working_we_o && !mem_we_o && working_register_o == rd_q + skip_pkg::INC_STEP;
   endproperty
   a_work: assert property (p_work) else $error("working variant wrong"); // RQ3

   property p_noskip;
      @(posedge clk_i) disable iff (rst_i)
      (done_o && !skip_o) |-> ready_o && !dummy_o;
   endproperty
   a_noskip: assert property (p_noskip) else $error("extra cycle without skip"); // RQ4

   property p_bit;
      @(posedge clk_i) disable iff (rst_i)
      (state == skip_pkg::st_exec && op_q == skip_pkg::skip_if_bit_nonzero) |=>
         skip_o == rd_q[$past(bit_q)] && !mem_we_o;
   endproperty
   a_bit: assert property (p_bit) else $error("bit test wrong"); // RQ5

   property p_nz;
      @(posedge clk_i) disable iff (rst_i)
      (state == skip_pkg::st_exec && op_q == skip_pkg::skip_if_nonzero) |=>
         mem_we_o && mem_wdata_o == rd_q && skip_o == (rd_q != skip_pkg::ZERO_BYTE);
   endproperty
   a_nz: assert property (p_nz) else $error("byte test wrong"); // RQ6

   property p_flags;
      @(posedge clk_i) disable iff (rst_i)
      done_o |-> !flag_we_o && !$past(flag_we_o);
   endproperty
   a_flags: assert property (p_flags) else $error("status flag written"); // RQ7

   property p_issue;
      @(posedge clk_i) disable iff (rst_i)
      mem_rd_o |-> ##2 done_o;
   endproperty
   a_issue: assert property (p_issue) else $error("done not two cycles after read"); // RQ4

   c_skip: cover property (@(posedge clk_i) disable iff (rst_i) skip_o);
   c_noskip: cover property (@(posedge clk_i) disable iff (rst_i) done_o && !skip_o);
   c_work: cover property (@(posedge clk_i) disable iff (rst_i) working_we_o);
   c_b2b: cover property (@(posedge clk_i) disable iff (rst_i) done_o ##1 mem_rd_o);

endmodule : skip_unit

`default_nettype wire

// ===== tb/data_mem_model.sv
`timescale 1ns/10ps
`default_nettype none

// ****************************************************************
// data memory seen from the skip unit
// ****************************************************************
module data_mem_model (
   input wire logic clk_i, // core clock
   input wire logic rd_i, // read strobe
   input wire logic we_i, // write strobe
   input wire logic [skip_pkg::ADDR_W-1:0] addr_i, // byte address
   input wire logic [skip_pkg::DATA_W-1:0] wdata_i, // write data
   output logic [skip_pkg::DATA_W-1:0] rdata_o // read data, one cycle late
);
   logic [skip_pkg::DATA_W-1:0] mem [256];
   logic [skip_pkg::DATA_W-1:0] rdata = 8'hA5;

   // sync read; outside a read the bus toggles so stale data never matches
   always @(posedge clk_i)
   begin
      if (rd_i)
         rdata <= mem[addr_i];
      else
         rdata <= ~rdata;
      if (we_i)
         mem[addr_i] <= wdata_i;
   end
   assign rdata_o = rdata;
endmodule : data_mem_model

`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none

`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin error_cnt++; \
   $display("Error %s expected %h seen %h", nm, ex, got); end end

module testbench;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic op_valid_i = 1'b0;
   skip_pkg::skip_op_t op_code_i = skip_pkg::increment_skip_if_zero;
   logic [7:0] op_addr_i = 8'h00;
   logic [2:0] op_bit_i = 3'h0;
   logic [7:0] mem_rdata_i, mem_addr_o, mem_wdata_o, working_register_o, work_exp;
   logic ready_o, mem_rd_o, mem_we_o, working_we_o, flag_we_o, done_o, skip_o, dummy_o;
   int error_cnt = 0;
   int checks_done = 0;
   int cycles = 0;

   // ****************************************************************
   // clock, design and memory
   // ****************************************************************
   always #12.5 clk_i = ~clk_i;

   skip_unit uut (.clk_i(clk_i), .rst_i(rst_i), .op_valid_i(op_valid_i),
      .op_code_i(op_code_i), .op_addr_i(op_addr_i), .op_bit_i(op_bit_i),
      .mem_rdata_i(mem_rdata_i), .ready_o(ready_o), .mem_rd_o(mem_rd_o),
      .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
      .working_register_o(working_register_o), .working_we_o(working_we_o),
      .flag_we_o(flag_we_o), .done_o(done_o), .skip_o(skip_o), .dummy_o(dummy_o));

   data_mem_model model (.clk_i(clk_i), .rd_i(mem_rd_o), .we_i(mem_we_o),
      .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i));

   // ****************************************************************
   // shared tasks
   // ****************************************************************
   // verdict in one place only
   task automatic test_done();
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : test_done

   // issue one op and judge its whole timeline; checks sampled at edges see settled values
   task automatic do_op(input skip_pkg::skip_op_t op, input logic [7:0] a, input logic [2:0] b,
                        input logic [7:0] v, input logic [7:0] exp_mem, input logic exp_skip,
                        input logic exp_wm, input logic exp_ww);
      int n;
      n = 0;
      model.mem[a] = v;
      @(posedge clk_i);
      op_valid_i <= 1'b1;
      op_code_i <= op;
      op_addr_i <= a;
      op_bit_i <= b;
      @(posedge clk_i);
      `CHK("ready", 1'b1, ready_o)
      op_valid_i <= 1'b0;
      // garbage on the address input once the op is taken must not matter
      op_addr_i <= ~a;
      do
      begin
         @(posedge clk_i);
         n++;
         `CHK("flag_we", 1'b0, flag_we_o)
         if (n == 1)
            `CHK("rd_addr", {1'b1, a}, {mem_rd_o, mem_addr_o})
      end
      while (done_o !== 1'b1 && n < 8);
      `CHK("latency", 3, n)
      `CHK("skip", {exp_skip, exp_skip}, {skip_o, dummy_o})
      `CHK("ready_at_done", !exp_skip, ready_o)
      `CHK("mem_we", exp_wm, mem_we_o)
      `CHK("work_we", exp_ww, working_we_o)
      if (exp_wm)
         `CHK("wdata", exp_mem, mem_wdata_o)
      @(posedge clk_i);
      `CHK("after", 3'b100, {ready_o, skip_o, dummy_o})
      `CHK("mem", exp_mem, model.mem[a])
      `CHK("work", work_exp, working_register_o)
   endtask : do_op

   // ****************************************************************
   // scenarios
   // ****************************************************************
   // memory increment: plain, then wrap to zero
   task automatic t_inc_mem();
      do_op(skip_pkg::increment_skip_if_zero, 8'h10, 3'h0, 8'h41, 8'h42, 1'b0, 1'b1, 1'b0);
      do_op(skip_pkg::increment_skip_if_zero, 8'hFF, 3'h0, 8'hFF, 8'h00, 1'b1, 1'b1, 1'b0);
   endtask : t_inc_mem

   // working variant leaves the byte alone
   task automatic t_inc_work();
      work_exp = 8'h80;
      do_op(skip_pkg::increment_to_working_skip_if_zero, 8'h20, 3'h0, 8'h7F, 8'h7F, 1'b0, 1'b0,
            1'b1);
      work_exp = 8'h00;
      do_op(skip_pkg::increment_to_working_skip_if_zero, 8'h21, 3'h0, 8'hFF, 8'hFF, 1'b1, 1'b0,
            1'b1);
   endtask : t_inc_work

   // every bit position, set alone and cleared alone
   task automatic t_bit();
      logic [7:0] p;
      for (int i = 0; i < 8; i++)
      begin
         p = 8'h01 << i;
         do_op(skip_pkg::skip_if_bit_nonzero, 8'h30, i[2:0], p, p, 1'b1, 1'b0, 1'b0);
         do_op(skip_pkg::skip_if_bit_nonzero, 8'h31, i[2:0], ~p, ~p, 1'b0, 1'b0, 1'b0);
      end
   endtask : t_bit

   // byte test: zero, high bit only, low bit only
   task automatic t_nonzero();
      do_op(skip_pkg::skip_if_nonzero, 8'h40, 3'h0, 8'h00, 8'h00, 1'b0, 1'b1, 1'b0);
      do_op(skip_pkg::skip_if_nonzero, 8'h41, 3'h0, 8'h80, 8'h80, 1'b1, 1'b1, 1'b0);
      do_op(skip_pkg::skip_if_nonzero, 8'hFE, 3'h0, 8'h01, 8'h01, 1'b1, 1'b1, 1'b0);
   endtask : t_nonzero

   // back to back: request held through the busy cycles, taken again as done shows
   task automatic t_b2b();
      model.mem[8'h50] = 8'h05;
      model.mem[8'h51] = 8'h3C;
      @(posedge clk_i);
      op_valid_i <= 1'b1;
      op_code_i <= skip_pkg::increment_skip_if_zero;
      op_addr_i <= 8'h50;
      @(posedge clk_i);
      `CHK("b2b_ready", 1'b1, ready_o)
      // second request waits while the unit is busy and must not be taken early
      op_code_i <= skip_pkg::skip_if_nonzero;
      op_addr_i <= 8'h51;
      @(posedge clk_i);
      @(posedge clk_i);
      `CHK("b2b_refused", 2'h0, {ready_o, mem_rd_o})
      @(posedge clk_i);
      `CHK("b2b_first", 5'h1C, {done_o, ready_o, mem_we_o, skip_o, dummy_o})
      `CHK("b2b_wdata1", 8'h06, mem_wdata_o)
      op_valid_i <= 1'b0;
      @(posedge clk_i);
      `CHK("b2b_issue", {1'b1, 8'h51}, {mem_rd_o, mem_addr_o})
      @(posedge clk_i);
      @(posedge clk_i);
      `CHK("b2b_second", 5'h17, {done_o, ready_o, mem_we_o, skip_o, dummy_o})
      `CHK("b2b_wdata2", 8'h3C, mem_wdata_o)
      @(posedge clk_i);
      `CHK("b2b_after", 3'h4, {ready_o, skip_o, dummy_o})
      `CHK("b2b_mem", 16'h063C, {model.mem[8'h50], model.mem[8'h51]})
   endtask : t_b2b

   // ****************************************************************
   // main sequence and hang guard
   // ****************************************************************
   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         error_cnt++;
         test_done();
      end
   end

   initial
   begin
      work_exp = 8'h00;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      `CHK("reset_state", {1'b1, 8'h00, 8'h00}, {ready_o, mem_addr_o, working_register_o})
      t_inc_mem();
      t_inc_work();
      t_bit();
      t_nonzero();
      t_b2b();
      test_done();
   end
endmodule : testbench

`default_nettype wire
